// ### rtl/rgb_pixel_write_port.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - bus width from two bits: 18, 16 or 6 bit; 11 is no mode
// - sample lines 17..0, 17..13 with 11..1, or 17..12 by width
// - low-active enable: low writes unless skip high, address moves
// - high-active enable: high advances, writes only with skip low
// - capture timed by host frame sync and clock, display rows by the internal oscillator; line sync is only read back in status
// - six-bit mode: three clock transfers form one pixel
// - six-bit transfer counter reset on every frame sync fall
// - broken pixel count upsets sequencing until next frame
// - timing source change takes effect after current frame completes
// - frame-sync mode holds front porch until next frame sync
// - frame-sync mode forbids partial display, scroll, interlace
// - each raster row lasts sixteen internal clocks
// - frame-sync mode when source field is 10 and RAM path 0
// - write address reloaded at every frame sync fall while capture is on
module rgb_pixel_write_port
  import rgb_port_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic frame_sync_n,
  input wire logic line_sync_n,
  input wire logic pixel_clock,
  input wire logic pixel_enable,
  input wire logic pixel_skip_qualifier,
  input wire logic [PIX_W-1:0] pixel_data_lines,
  output logic ram_wr_en,
  output logic [ADDR_W-1:0] ram_wr_addr,
  output logic [PIX_W-1:0] ram_wr_data,
  output logic sync_mode,
  output logic front_porch,
  output logic partial_display_en,
  output logic vertical_scroll_en,
  output logic interlace_en,
  output logic width_invalid
);
  localparam int SYNC_W = PIX_W + 5;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [TIM_W-1:0] tim;
    logic [ADDR_W-1:0] base;
    logic [31:0] rdata;
    logic [15:0] osc;
    logic [3:0] sub;
    logic [7:0] row;
    seq_t seq;
    logic act_sync;
    logic fs_d;
    logic pclk_d;
    logic [ADDR_W-1:0] addr;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [PIX_W-1:0] wdata;
    logic partial;
    logic scroll;
    logic interlace;
    logic front;
    logic width_bad;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  logic [SYNC_W-1:0] pins_s;
  logic fs_s;
  logic ls_s;
  logic pclk_s;
  logic en_s;
  logic skip_s;
  logic [PIX_W-1:0] data_s;
  logic fs_fall;
  logic pclk_rise;
  logic [1:0] width_sel;
  logic enable_polarity;
  logic sync_req;
  logic capture_on;
  logic enable_active;
  logic osc_tick;
  logic row_end;
  logic [8:0] row_next;
  logic [7:0] disp_rows;
  logic [3:0] bp_rows;
  logic [3:0] fp_rows;
  logic disp_done;
  logic frame_done;

  pix_if pix();

  // every pin, the pixel clock included, is sampled by ref_clk
  sync_2ff #(.W(SYNC_W)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({frame_sync_n, line_sync_n, pixel_clock, pixel_enable,
      pixel_skip_qualifier, pixel_data_lines}),
    .q(pins_s)
  );

  assign {fs_s, ls_s, pclk_s, en_s, skip_s, data_s} = pins_s;
  assign fs_fall = state_r.fs_d && !fs_s;
  assign pclk_rise = !state_r.pclk_d && pclk_s;

  assign width_sel = state_r.cfg[CFG_WIDTH_LSB +: 2];
  assign enable_polarity = state_r.cfg[CFG_EPL_BIT];
  assign sync_req = state_r.cfg[CFG_SRC_LSB +: 2] == SRC_FRAME_SYNC
    && !state_r.cfg[CFG_RAMPATH_BIT];
  assign capture_on = state_r.cfg[CFG_RAMPATH_BIT]
    && width_sel != WIDTH_BAD;
  assign enable_active = enable_polarity ? pix.enable : !pix.enable;

  pixel_assembler u_asm (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sample(pclk_rise),
    .restart(fs_fall),
    .width_sel(width_sel),
    .lines(data_s),
    .enable_in(en_s),
    .skip_in(skip_s),
    .pix(pix.src)
  );

  assign disp_rows = state_r.tim[TIM_ROWS_LSB +: 8];
  assign bp_rows = state_r.tim[TIM_BP_LSB +: 4];
  assign fp_rows = state_r.tim[TIM_FP_LSB +: 4];
  assign osc_tick = state_r.osc == 16'(OSC_DIV - 1);
  assign row_end = osc_tick && state_r.sub == ROW_LAST_CLK;
  assign row_next = {1'b0, state_r.row} + 9'h001;
  assign disp_done = state_r.seq == SQ_DISP && row_end
    && row_next >= {1'b0, disp_rows};
  // a frame counts as shown once its last display row is out
  assign frame_done = disp_done || state_r.seq == SQ_WAIT;

  always_comb begin
    state_nxt = state_r;
    state_nxt.wr_en = 1'b0;
    state_nxt.fs_d = fs_s;
    state_nxt.pclk_d = pclk_s;

    // register port
    if (reg_wr) begin
      case (reg_addr)
        REG_CFG: state_nxt.cfg = reg_wdata[CFG_W-1:0];
        REG_TIMING: state_nxt.tim = reg_wdata[TIM_W-1:0];
        REG_BASE: state_nxt.base = reg_wdata[ADDR_W-1:0];
        default: ;
      endcase
    end
    state_nxt.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_CFG: state_nxt.rdata[CFG_W-1:0] = state_r.cfg;
        REG_TIMING: state_nxt.rdata[TIM_W-1:0] = state_r.tim;
        REG_BASE: state_nxt.rdata[ADDR_W-1:0] = state_r.base;
        REG_STATUS: begin
          state_nxt.rdata[ST_SYNC_BIT] = state_r.act_sync;
          state_nxt.rdata[ST_FRONT_BIT] = state_r.front;
          state_nxt.rdata[ST_PHASE_LSB +: 2] = pix.phase;
          state_nxt.rdata[ST_WBAD_BIT] = state_r.width_bad;
          state_nxt.rdata[ST_LINE_BIT] = ls_s;
          state_nxt.rdata[ST_FRAME_BIT] = fs_s;
          state_nxt.rdata[ST_ADDR_LSB +: ADDR_W] = state_r.addr;
        end
        default: ;
      endcase
    end

    // internal oscillator stands in for the on-chip clock
    state_nxt.osc = osc_tick ? 16'h0000 : state_r.osc + 16'h0001;
    if (osc_tick) begin
      state_nxt.sub = state_r.sub + 4'h1;
    end

    // mode changes wait for the shown frame to finish
    if (frame_done) begin
      state_nxt.act_sync = sync_req;
    end

    // raster sequencer
    case (state_r.seq)
      SQ_BACK: begin
        if (row_end) begin
          state_nxt.row = row_next[7:0];
          if (row_next >= {5'h00, bp_rows}) begin
            state_nxt.seq = SQ_DISP;
            state_nxt.row = 8'h00;
          end
        end
      end
      SQ_DISP: begin
        if (row_end) begin
          state_nxt.row = row_next[7:0];
          if (disp_done) begin
            state_nxt.row = 8'h00;
            state_nxt.seq = state_nxt.act_sync ? SQ_WAIT : SQ_FRONT;
          end
        end
      end
      SQ_FRONT: begin
        if (row_end) begin
          state_nxt.row = row_next[7:0];
          if (row_next >= {5'h00, fp_rows}) begin
            state_nxt.seq = SQ_BACK;
            state_nxt.row = 8'h00;
          end
        end
      end
      SQ_WAIT: begin
        // parked in front porch; only a frame sync or leaving
        // frame-sync mode ends it
        if (!state_nxt.act_sync) begin
          state_nxt.seq = SQ_BACK;
          state_nxt.row = 8'h00;
          state_nxt.sub = 4'h0;
        end
      end
      default: begin
        state_nxt.seq = SQ_BACK;
        state_nxt.row = 8'h00;
      end
    endcase
    if (state_r.act_sync && fs_fall) begin
      // frame sync starts a new frame in frame-sync mode
      state_nxt.seq = SQ_BACK;
      state_nxt.row = 8'h00;
      state_nxt.sub = 4'h0;
      state_nxt.osc = 16'h0000;
    end

    // pixel writes; the reload wins over a pixel in the same cycle
    if (capture_on && fs_fall) begin
      state_nxt.addr = state_r.base;
    end else if (capture_on && pix.stb && enable_active) begin
      state_nxt.addr = state_r.addr + ADDR_W'(1);
      if (!pix.skip) begin
        state_nxt.wr_en = 1'b1;
        state_nxt.wr_addr = state_r.addr;
        state_nxt.wdata = pix.data;
      end
    end

    state_nxt.front = state_nxt.seq == SQ_FRONT
      || state_nxt.seq == SQ_WAIT;
    state_nxt.partial = state_r.cfg[CFG_PARTIAL_BIT]
      && !state_nxt.act_sync;
    state_nxt.scroll = state_r.cfg[CFG_SCROLL_BIT]
      && !state_nxt.act_sync;
    state_nxt.interlace = state_r.cfg[CFG_INTERLACE_BIT]
      && !state_nxt.act_sync;
    state_nxt.width_bad = width_sel == WIDTH_BAD;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= '0;
      state_r.cfg <= CFG_RESET;
      state_r.tim <= TIM_RESET;
      state_r.base <= BASE_RESET;
      state_r.seq <= SQ_BACK;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata = state_r.rdata;
  assign ram_wr_en = state_r.wr_en;
  assign ram_wr_addr = state_r.wr_addr;
  assign ram_wr_data = state_r.wdata;
  assign sync_mode = state_r.act_sync;
  assign front_porch = state_r.front;
  assign partial_display_en = state_r.partial;
  assign vertical_scroll_en = state_r.scroll;
  assign interlace_en = state_r.interlace;
  assign width_invalid = state_r.width_bad;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_pixel_taken;
    capture_on && pix.stb && enable_active && !fs_fall;
  endsequence

  a_width_reserved: assert property (
    width_sel == WIDTH_BAD |=> width_invalid ##1 !ram_wr_en)
    else $error("reserved width not flagged or still writing");

  a_write_valid: assert property (
    s_pixel_taken ##0 !pix.skip
    |=> ram_wr_en && ram_wr_data == $past(pix.data)
      && ram_wr_addr == $past(state_r.addr))
    else $error("qualified pixel not written");

  a_skip_advance: assert property (
    s_pixel_taken ##0 pix.skip
    |=> !ram_wr_en && state_r.addr == $past(state_r.addr) + ADDR_W'(1))
    else $error("skipped pixel wrote or did not advance");

  a_enable_hold: assert property (
    pix.stb && !enable_active && !fs_fall
    |=> !ram_wr_en && $stable(state_r.addr))
    else $error("inactive enable moved address or wrote");

  a_addr_reload: assert property (
    capture_on && fs_fall |=> state_r.addr == $past(state_r.base))
    else $error("address not reloaded at frame sync fall");

  a_porch_hold: assert property (
    state_r.seq == SQ_WAIT && sync_req && !fs_fall
    |=> state_r.seq == SQ_WAIT && front_porch)
    else $error("left front porch without frame sync");

  a_features_off: assert property (
    sync_mode |-> !partial_display_en && !vertical_scroll_en
      && !interlace_en)
    else $error("feature enabled in frame-sync mode");

  a_mode_frame_end: assert property (
    $changed(sync_mode) |-> $past(frame_done))
    else $error("timing source changed mid-frame");

  a_row_length: assert property (
    $changed(state_r.row) && state_r.row != 8'h00
    |-> $past(state_r.sub) == ROW_LAST_CLK && $past(osc_tick))
    else $error("raster row not sixteen internal clocks");

  a_sync_entry: assert property (
    frame_done && sync_req |=> sync_mode)
    else $error("frame-sync mode not entered at frame end");
endmodule // rgb_pixel_write_port

// ### rtl/rgb_port_pkg.sv
package rgb_port_pkg;

  // reference clock and internal oscillator period
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PERIOD_NS = 4630;
  localparam int OSC_DIV_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [3:0] ROW_LAST_CLK = 4'hf;

  localparam int PIX_W = 18;
  localparam int ADDR_W = 15;
  localparam int REG_AW = 8;

  // bus width encodings
  localparam logic [1:0] WIDTH_18 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_6 = 2'h2;
  localparam logic [1:0] WIDTH_BAD = 2'h3;
  localparam logic [PIX_W-1:0] MASK_16 = 18'h3effe;

  // display timing source encodings
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_FRAME_SYNC = 2'h2;

  // register offsets
  localparam logic [REG_AW-1:0] REG_CFG = 8'h00;
  localparam logic [REG_AW-1:0] REG_TIMING = 8'h04;
  localparam logic [REG_AW-1:0] REG_BASE = 8'h08;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h0c;

  // configuration field positions
  localparam int CFG_W = 9;
  localparam int CFG_WIDTH_LSB = 0;
  localparam int CFG_EPL_BIT = 2;
  localparam int CFG_SRC_LSB = 3;
  localparam int CFG_RAMPATH_BIT = 5;
  localparam int CFG_PARTIAL_BIT = 6;
  localparam int CFG_SCROLL_BIT = 7;
  localparam int CFG_INTERLACE_BIT = 8;

  // timing field positions
  localparam int TIM_W = 16;
  localparam int TIM_ROWS_LSB = 0;
  localparam int TIM_BP_LSB = 8;
  localparam int TIM_FP_LSB = 12;

  // status field positions
  localparam int ST_SYNC_BIT = 0;
  localparam int ST_FRONT_BIT = 1;
  localparam int ST_PHASE_LSB = 2;
  localparam int ST_WBAD_BIT = 4;
  localparam int ST_LINE_BIT = 5;
  localparam int ST_FRAME_BIT = 6;
  localparam int ST_ADDR_LSB = 16;

  // reset values: 176 rows, back porch 3, front porch 5
  localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;
  localparam logic [TIM_W-1:0] TIM_RESET = 16'h53b0;
  localparam logic [ADDR_W-1:0] BASE_RESET = 15'h0000;

  typedef enum logic [1:0] {SQ_BACK, SQ_DISP, SQ_FRONT, SQ_WAIT} seq_t;

endpackage

// ### rtl/pix_if.sv
`timescale 1ns/1ps
interface pix_if;
  import rgb_port_pkg::*;
  logic stb;
  logic [PIX_W-1:0] data;
  logic enable;
  logic skip;
  logic [1:0] phase;
  modport src(output stb, output data, output enable, output skip,
    output phase);
  modport dst(input stb, input data, input enable, input skip,
    input phase);
endinterface

// ### rtl/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_t;

  sync_t state_r;
  sync_t state_nxt;

  always_comb begin
    state_nxt.meta = d;
    state_nxt.q = state_r.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign q = state_r.q;
endmodule // sync_2ff

// ### rtl/pixel_assembler.sv
`timescale 1ns/1ps
module pixel_assembler
  import rgb_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sample,
  input wire logic restart,
  input wire logic [1:0] width_sel,
  input wire logic [PIX_W-1:0] lines,
  input wire logic enable_in,
  input wire logic skip_in,
  pix_if.src pix
);
  typedef struct packed {
    logic [1:0] phase;
    logic [11:0] acc;
    logic stb;
    logic [PIX_W-1:0] data;
    logic enable;
    logic skip;
  } asm_t;

  asm_t state_r;
  asm_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.stb = 1'b0;
    if (restart) begin
      // a lost transfer is only repaired here, once per frame
      state_nxt.phase = 2'h0;
    end else if (sample) begin
      case (width_sel)
        WIDTH_18: begin
          state_nxt.data = lines;
          state_nxt.stb = 1'b1;
        end
        WIDTH_16: begin
          state_nxt.data = lines & MASK_16;
          state_nxt.stb = 1'b1;
        end
        WIDTH_6: begin
          case (state_r.phase)
            2'h0: begin
              state_nxt.acc[11:6] = lines[17:12];
              state_nxt.phase = 2'h1;
            end
            2'h1: begin
              state_nxt.acc[5:0] = lines[17:12];
              state_nxt.phase = 2'h2;
            end
            default: begin
              state_nxt.data = {state_r.acc, lines[17:12]};
              state_nxt.stb = 1'b1;
              state_nxt.phase = 2'h0;
            end
          endcase
        end
        default: ; // reserved width: nothing is taken
      endcase
      state_nxt.enable = enable_in;
      state_nxt.skip = skip_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pix.stb = state_r.stb;
  assign pix.data = state_r.data;
  assign pix.enable = state_r.enable;
  assign pix.skip = state_r.skip;
  assign pix.phase = state_r.phase;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_six_bit_pack: assert property (
    width_sel == WIDTH_6 && sample && !restart && state_r.phase == 2'h2
    |=> pix.stb && pix.data[5:0] == $past(lines[17:12])
      && pix.data[17:6] == $past(state_r.acc))
    else $error("six-bit pixel not packed on third transfer");

  a_six_bit_wait: assert property (
    width_sel == WIDTH_6 && state_r.phase != 2'h2 |=> !pix.stb)
    else $error("six-bit pixel issued before third transfer");

  a_phase_restart: assert property (
    restart |=> pix.phase == 2'h0 && !pix.stb)
    else $error("transfer counter not reset on frame sync fall");
endmodule // pixel_assembler

// ### test/pixel_host.sv
`timescale 1ns/1ps
module pixel_host (
  output logic frame_sync_n,
  output logic line_sync_n,
  output logic pixel_clock,
  output logic pixel_enable,
  output logic pixel_skip_qualifier,
  output logic [17:0] pixel_data_lines
);
  initial begin
    frame_sync_n = 1'b1;
    line_sync_n = 1'b1;
    pixel_clock = 1'b0;
    // idle enable is the inactive level for low-active polarity
    pixel_enable = 1'b1;
    pixel_skip_qualifier = 1'b0;
    pixel_data_lines = 18'h0;
  end

  // offset of 2 ns keeps pin edges off the reference clock grid when a send starts on a clock edge
  task automatic send(input logic [17:0] d, input logic en, input logic sk);
    #2;
    pixel_data_lines = d;
    pixel_enable = en;
    pixel_skip_qualifier = sk;
    #62.5 pixel_clock = 1'b1;
    #62.5 pixel_clock = 1'b0;
    // hold is over: show a changed value rather than the old one
    pixel_data_lines = ~d;
  endtask

  // unused low lines carry ones, which the port must ignore
  task automatic send6(input logic [5:0] r, input logic [5:0] g,
    input logic [5:0] b, input logic en, input logic sk);
    send({r, 12'hfff}, en, sk);
    send({g, 12'hfff}, en, sk);
    send({b, 12'hfff}, en, sk);
  endtask

  task automatic frame();
    #2;
    frame_sync_n = 1'b0;
    line_sync_n = 1'b0;
    #250;
    frame_sync_n = 1'b1;
    line_sync_n = 1'b1;
    #250;
  endtask
endmodule // pixel_host

// ### test/rgb_pixel_write_port_test.sv
`timescale 1ns/1ps
module rgb_pixel_write_port_test;
  import rgb_port_pkg::*;
  localparam int DIV = 2;
  logic ref_clk;
  logic rst_n;
  logic [REG_AW-1:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic frame_sync_n;
  logic line_sync_n;
  logic pixel_clock;
  logic pixel_enable;
  logic pixel_skip_qualifier;
  logic [PIX_W-1:0] pixel_data_lines;
  logic ram_wr_en;
  logic [ADDR_W-1:0] ram_wr_addr;
  logic [PIX_W-1:0] ram_wr_data;
  logic sync_mode;
  logic front_porch;
  logic partial_display_en;
  logic vertical_scroll_en;
  logic interlace_en;
  logic width_invalid;
  logic [32:0] wq[$];
  logic [31:0] rv;
  int err_total;
  int check_count;
  int n;

  rgb_pixel_write_port #(.OSC_DIV(DIV)) rgb_pixel_write_port_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_sync_n(frame_sync_n),
    .line_sync_n(line_sync_n), .pixel_clock(pixel_clock),
    .pixel_enable(pixel_enable),
    .pixel_skip_qualifier(pixel_skip_qualifier),
    .pixel_data_lines(pixel_data_lines), .ram_wr_en(ram_wr_en),
    .ram_wr_addr(ram_wr_addr), .ram_wr_data(ram_wr_data),
    .sync_mode(sync_mode), .front_porch(front_porch),
    .partial_display_en(partial_display_en),
    .vertical_scroll_en(vertical_scroll_en),
    .interlace_en(interlace_en), .width_invalid(width_invalid));

  pixel_host pixel_host_i (
    .frame_sync_n(frame_sync_n), .line_sync_n(line_sync_n),
    .pixel_clock(pixel_clock), .pixel_enable(pixel_enable),
    .pixel_skip_qualifier(pixel_skip_qualifier),
    .pixel_data_lines(pixel_data_lines));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (ram_wr_en === 1'b1) begin
      wq.push_back({ram_wr_addr, ram_wr_data});
    end
  end

  task automatic wt(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [REG_AW-1:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp,
    input logic got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // pops the oldest captured write, so stray extra writes show up later
  task automatic chk_wr(input logic [ADDR_W-1:0] a,
    input logic [PIX_W-1:0] d);
    check_count++;
    if (wq.size() == 0 || wq[0] !== {a, d}) begin
      err_total++;
      $display("CHECK FAILED ram write expected %h seen %h", {a, d},
        (wq.size() == 0) ? 33'h0 : wq[0]);
    end
    if (wq.size() > 0) begin
      void'(wq.pop_front());
    end
  endtask

  task automatic start(input logic [31:0] cfg, input logic [31:0] base);
    wr(REG_CFG, cfg);
    wr(REG_BASE, base);
    wq.delete();
    // a frame sync pulse passes between register traffic and pixels
    pixel_host_i.frame();
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #500000;
    err_total++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_total = 0;
    check_count = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(REG_CFG, rv);
    chk("cfg reset", 32'h0, rv);
    rd(REG_TIMING, rv);
    chk("timing reset", 32'h53b0, rv);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, rv);
    chk("unmapped", 32'h0, rv);
    wr(REG_TIMING, 32'h0000_1104);
    // low-active enable, 18-bit bus, capture on
    start(32'h0000_0020, 32'h0000_0100);
    chk_bit("width bad", 1'b0, width_invalid);
    pixel_host_i.send(18'h2a5c3, 1'b0, 1'b0);
    pixel_host_i.send(18'h11111, 1'b0, 1'b1);
    pixel_host_i.send(18'h22222, 1'b1, 1'b0);
    pixel_host_i.send(18'h3c00f, 1'b0, 1'b0);
    wt(8);
    chk_wr(15'h0100, 18'h2a5c3);
    chk_wr(15'h0102, 18'h3c00f);
    chk("extra writes", 32'h0, 32'(wq.size()));
    // high-active enable; the reload must land back on the base
    start(32'h0000_0024, 32'h0000_0200);
    pixel_host_i.send(18'h11111, 1'b0, 1'b0);
    pixel_host_i.send(18'h0f0f0, 1'b1, 1'b0);
    pixel_host_i.send(18'h22222, 1'b1, 1'b1);
    pixel_host_i.send(18'h30303, 1'b1, 1'b0);
    wt(8);
    chk_wr(15'h0200, 18'h0f0f0);
    chk_wr(15'h0202, 18'h30303);
    chk("extra writes", 32'h0, 32'(wq.size()));
    start(32'h0000_0021, 32'h0000_0010);
    pixel_host_i.send(18'h3ffff, 1'b0, 1'b0);
    wt(8);
    chk_wr(15'h0010, 18'h3effe);
    // six-bit: a lone stray transfer, then a frame resynchronises
    start(32'h0000_0022, 32'h0000_0020);
    pixel_host_i.send(18'h3f000, 1'b0, 1'b0);
    pixel_host_i.frame();
    pixel_host_i.send6(6'h2a, 6'h15, 6'h3c, 1'b0, 1'b0);
    pixel_host_i.send6(6'h01, 6'h02, 6'h03, 1'b0, 1'b0);
    wt(8);
    chk_wr(15'h0020, 18'h2a57c);
    chk_wr(15'h0021, 18'h01083);
    chk("extra writes", 32'h0, 32'(wq.size()));
    start(32'h0000_0023, 32'h0000_0030);
    chk_bit("width bad", 1'b1, width_invalid);
    pixel_host_i.send(18'h12345, 1'b0, 1'b0);
    wt(8);
    chk("bad width writes", 32'h0, 32'(wq.size()));
    // internal timing passes the feature requests through
    wr(REG_CFG, 32'h0000_01c0);
    wt(2);
    chk("features", 32'h7, {29'h0, partial_display_en,
      vertical_scroll_en, interlace_en});
    // ask for the change just after a frame ends, so that no frame end
    // can fall within the next few cycles
    for (n = 0; n < 400 && front_porch !== 1'b1; n++) wt(1);
    // no system-bus RAM traffic here
    wr(REG_CFG, 32'h0000_01d0);
    wt(2);
    chk_bit("early mode", 1'b0, sync_mode);
    for (n = 0; n < 7000 && sync_mode !== 1'b1; n++) wt(1);
    chk_bit("sync mode", 1'b1, sync_mode);
    wt(2);
    chk("features", 32'h0, {29'h0, partial_display_en,
      vertical_scroll_en, interlace_en});
    wt(300);
    chk_bit("parked", 1'b1, front_porch);
    rd(REG_STATUS, rv);
    chk_bit("status sync", 1'b1, rv[ST_SYNC_BIT]);
    fork
      pixel_host_i.frame();
      begin
        for (n = 0; n < 200 && front_porch !== 1'b0; n++) wt(1);
        for (n = 0; n < 400 && front_porch !== 1'b1; n++) wt(1);
      end
    join
    // one back porch row plus four display rows, 16 ticks each
    chk("porch gap", 32'((1 + 4) * 16 * DIV), 32'(n));
    wt(300);
    chk_bit("parked again", 1'b1, front_porch);
    wrap_up();
  end
endmodule // rgb_pixel_write_port_test
